// ---- bench/cgl_far_equipment.sv ----
// far-side equipment on the camera connector: trigger source and shared wire
// assumes both lines are pulled up when nobody drives them
`timescale 1ns/1ps
module cgl_far_equipment (
	input wire logic clock,
	input wire logic bidirLineOut,
	input wire logic bidirLineOe,
	input wire logic equipDrive,
	input wire logic equipLevel,
	input wire logic trigReq,
	input wire logic triggerAcceptReady,
	output logic bidirWire,
	output logic inputOnlyLine
);
	int pulseLeft = 0;
	// released wire goes to its pull-up, never keeps the last driven level
	assign bidirWire = bidirLineOe ? bidirLineOut : (equipDrive ? equipLevel : 1'b1);
	assign inputOnlyLine = pulseLeft == 0;
	always @(posedge clock) begin
		if (trigReq && triggerAcceptReady) begin
			pulseLeft <= 4;
		end else if (pulseLeft != 0) begin
			pulseLeft <= pulseLeft - 1;
		end
	end
endmodule

// ---- bench/cgl_line_ctrl_test.sv ----
// self-checking bench for the camera line block
// assumes the far-side equipment model and the bound checker
`timescale 1ns/1ps
`include "cgl_map.svh"
module cgl_line_ctrl_test;
	logic clock = 1'b0, rst = 1'b1, clockEnable = 1'b1, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, srcLvl = 1'b0, equipDrive = 1'b0, equipLevel = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rdVal;
	logic [2:0] kick = 3'h0;
	logic pready, pslverr, rdErr, bidirLineOut, bidirLineOe, outputOnlyLine;
	logic bidirInputAsserted, bidirWire, inputOnlyLine;
	int check_count = 0, bad_count = 0, cycles = 0, lead, width;
	cgl_line_ctrl dut (.clock, .rst, .clockEnable, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .inputOnlyLine, .bidirLineIn(bidirWire), .bidirLineOut,
		.bidirLineOe, .outputOnlyLine, .bidirInputAsserted, .exposureWindowActive(srcLvl),
		.framePeriodActive(srcLvl), .imageSendingFlag(srcLvl), .triggerAcceptReady(srcLvl),
		.exposureBeginEvent(kick[1]), .captureRequestEvent(kick[2]));
	cgl_far_equipment far (.clock, .bidirLineOut, .bidirLineOe, .equipDrive, .equipLevel,
		.trigReq(kick[0]), .triggerAcceptReady(srcLvl), .bidirWire, .inputOnlyLine);
	always #2.5 clock = ~clock;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 10000) begin
			bad_count++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chkBit(input logic g, input logic e, input string m);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	task automatic chk32(input logic [31:0] g, input logic [31:0] e, input string m);
		chkBit(g === e, 1'b1, m);
	endtask
	// call just after a rising edge; returns one edge after the answer
	// waits for pready however long it takes; only the cycle timeout ends a hang
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		rdVal = prdata;
		rdErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask
	task automatic waitPin(input logic v, output int n);
		n = 0;
		while (outputOnlyLine !== v && n < 1000) begin
			@(posedge clock);
			n++;
		end
	endtask
	initial begin
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		chkBit(outputOnlyLine, 1'b1, "idle pin");
		chkBit(bidirLineOe, 1'b0, "idle oe");
		apb(1'b0, `CGL_OFS_LINE_CTRL, 32'h0000_0000);
		chk32(rdVal, 32'h0000_0100, "ctrl reset");
		apb(1'b0, `CGL_OFS_TMR_DUR, 32'h0000_0000);
		chk32(rdVal, 32'h0000_0000, "dur reset");
		apb(1'b1, `CGL_OFS_TMR_DELAY, 32'hFFFF_FFFF);
		apb(1'b0, `CGL_OFS_TMR_DELAY, 32'h0000_0000);
		chk32(rdVal, 32'h001E_8480, "delay clamp");
		apb(1'b0, `CGL_OFS_STATUS, 32'h0000_0000);
		chk32(rdVal, 32'h0000_0003, "status reset");
		apb(1'b1, `CGL_OFS_LINE_CTRL, 32'h0003_0077);
		apb(1'b0, `CGL_OFS_LINE_CTRL, 32'h0000_0000);
		chk32(rdVal, 32'h0000_0000, "bad codes off");
		apb(1'b0, 12'h010, 32'h0000_0000);
		chkBit(rdErr, 1'b1, "unmapped");
		$display("test registers done");
		srcLvl <= 1'b1;
		for (int p = 0; p < 2; p++) begin
			for (int s = 0; s < 7; s++) begin
				apb(1'b1, `CGL_OFS_LINE_CTRL, {19'h0_0000, 1'b1, 1'b0, p[0], p[0], 1'b1,
					1'b0, s[2:0], 1'b0, s[2:0]});
				repeat (2) @(posedge clock);
				chkBit(outputOnlyLine, (s > 1) ~^ p[0], "out pin");
				chkBit(bidirLineOe, s != 0, "bidir oe");
				chkBit(bidirLineOut, (s > 1) ~^ p[0], "bidir pin");
				chkBit(bidirInputAsserted, s == 0 && p[0], "bidir in");
			end
		end
		$display("test sources done");
		equipDrive <= 1'b1;
		apb(1'b1, `CGL_OFS_LINE_CTRL, 32'h0000_1002);
		repeat (2) @(posedge clock);
		chkBit(bidirLineOe, 1'b0, "dir oe");
		chkBit(bidirInputAsserted, 1'b1, "dir in");
		equipDrive <= 1'b0;
		$display("test direction done");
		apb(1'b1, `CGL_OFS_TMR_DELAY, 32'h0000_0002);
		apb(1'b1, `CGL_OFS_TMR_DUR, 32'h0000_0001);
		for (int k = 0; k < 3; k++) begin
			apb(1'b1, `CGL_OFS_LINE_CTRL, {14'h0000, k[1:0], 16'h0510});
			kick <= 3'h1 << k;
			@(posedge clock);
			kick <= 3'h0;
			waitPin(1'b1, lead);
			// a frozen clock enable must stretch the pulse by the frozen cycles
			if (k == 2) begin
				clockEnable <= 1'b0;
				repeat (50) @(posedge clock);
				chkBit(outputOnlyLine, 1'b1, "frozen pin");
				clockEnable <= 1'b1;
			end
			waitPin(1'b0, width);
			chkBit(lead inside {[398:410]}, 1'b1, "delay");
			chkBit(width inside {[198:202]}, 1'b1, "duration");
		end
		$display("test timer done");
		report_and_stop();
	end
endmodule

// ---- bench/cgl_line_props.sv ----
// checker for the camera line block: bus timing and pin relations
// assumes clockEnable stays high around every transfer
`timescale 1ns/1ps
module cgl_line_props (
	input wire logic clock,
	input wire logic rst,
	input wire logic clockEnable,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic bidirLineOe,
	input wire logic outputOnlyLine,
	input wire logic bidirInputAsserted
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	a_one_wait: assert property (psel && penable && !pready && clockEnable |=> pready)
		else $error("access not answered");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held");
	a_idle_quiet: assert property (!psel |=> !pready)
		else $error("ready while idle");
	a_ready_cause: assert property (pready |-> $past(psel) && $past(penable))
		else $error("ready without access");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_off_released: assert property ($past(rst) |-> outputOnlyLine && !bidirLineOe)
		else $error("pins not idle after reset");
	a_drive_mute: assert property (bidirLineOe && $past(bidirLineOe) |-> !bidirInputAsserted)
		else $error("input seen while driving");
	cover property (pready && pwrite);
	cover property (pready && pslverr);
	cover property (bidirLineOe);
endmodule
bind cgl_line_ctrl cgl_line_props chk (.clock, .rst, .clockEnable, .psel, .penable, .pwrite,
	.prdata, .pready, .pslverr, .bidirLineOe, .outputOnlyLine, .bidirInputAsserted);

// ---- rtl/cgl_line_ctrl.sv ----
// camera general purpose line control with APB register access
// assumes all inputs synchronous to clock; pad buffers outside resolve the bidirectional wire
`timescale 1ns/1ps
`include "cgl_map.svh"
module cgl_line_ctrl (
	input wire logic clock,
	input wire logic rst,
	input wire logic clockEnable,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic inputOnlyLine,
	input wire logic bidirLineIn,
	output logic bidirLineOut,
	output logic bidirLineOe,
	output logic outputOnlyLine,
	output logic bidirInputAsserted,
	input wire logic exposureWindowActive,
	input wire logic framePeriodActive,
	input wire logic imageSendingFlag,
	input wire logic triggerAcceptReady,
	input wire logic exposureBeginEvent,
	input wire logic captureRequestEvent
);
	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	logic [2:0] bidirSel, next_bidirSel;
	logic [2:0] outSel, next_outSel;
	logic bidirDirOut, next_bidirDirOut;
	logic bidirPolHigh, next_bidirPolHigh;
	logic outPolHigh, next_outPolHigh;
	logic inPolHigh, next_inPolHigh;
	logic softwareOutputLevel, next_softwareOutputLevel;
	logic [1:0] startSel, next_startSel;
	logic [20:0] delayUs, next_delayUs;
	logic [20:0] durationUs, next_durationUs;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;
	logic next_bidirLineOut, next_bidirLineOe, next_outputOnlyLine;
	logic next_bidirInputAsserted;
	logic inputPinAsserted, inputPrev, timerStart;
	logic pulseTimerActive;
	logic wrAccess, rdAccess, addrHit;
	logic [31:0] ctrlWord;

	function automatic logic selectSource(input logic [2:0] sel, input logic timerAct,
		input logic softLvl, input logic expo, input logic frame, input logic send,
		input logic rdy);
		logic val;
		val = 1'b0;
		unique case (sel)
			3'h1: val = timerAct;
			3'h2: val = softLvl;
			3'h3: val = expo;
			3'h4: val = frame;
			3'h5: val = send;
			3'h6: val = rdy;
			default: val = 1'b0;
		endcase
		return val;
	endfunction

	// active level to pin level: low active inverts
	function automatic logic applyPolarity(input logic level, input logic polHigh);
		return polHigh ? level : ~level;
	endfunction

	function automatic logic [20:0] clampUs(input logic [31:0] value);
		return (value > 32'(`CGL_TMR_MAX_US)) ? 21'(`CGL_TMR_MAX_US) : value[20:0];
	endfunction

	assign wrAccess = psel & penable & pwrite & ~pready;
	assign rdAccess = psel & penable & ~pwrite & ~pready;
	assign addrHit = (paddr == `CGL_OFS_LINE_CTRL) || (paddr == `CGL_OFS_TMR_DELAY)
		|| (paddr == `CGL_OFS_TMR_DUR) || (paddr == `CGL_OFS_STATUS);

	always_comb begin
		ctrlWord = 32'h0000_0000;
		ctrlWord[`CGL_BIDIR_SEL_LSB +: 3] = bidirSel;
		ctrlWord[`CGL_OUT_SEL_LSB +: 3] = outSel;
		ctrlWord[`CGL_BIDIR_DIR_BIT] = bidirDirOut;
		ctrlWord[`CGL_BIDIR_POL_BIT] = bidirPolHigh;
		ctrlWord[`CGL_OUT_POL_BIT] = outPolHigh;
		ctrlWord[`CGL_IN_POL_BIT] = inPolHigh;
		ctrlWord[`CGL_SW_LEVEL_BIT] = softwareOutputLevel;
		ctrlWord[`CGL_START_SEL_LSB +: 2] = startSel;
	end

	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	// one wait state: pready rises the cycle after the access phase begins
	always_comb begin
		next_bidirSel = bidirSel;
		next_outSel = outSel;
		next_bidirDirOut = bidirDirOut;
		next_bidirPolHigh = bidirPolHigh;
		next_outPolHigh = outPolHigh;
		next_inPolHigh = inPolHigh;
		next_softwareOutputLevel = softwareOutputLevel;
		next_startSel = startSel;
		next_delayUs = delayUs;
		next_durationUs = durationUs;
		next_prdata = prdata;
		next_pready = wrAccess | rdAccess;
		next_pslverr = (wrAccess | rdAccess) & ~addrHit;
		if (wrAccess && paddr == `CGL_OFS_LINE_CTRL) begin
			next_bidirSel = pwdata[`CGL_BIDIR_SEL_LSB +: 3];
			next_outSel = pwdata[`CGL_OUT_SEL_LSB +: 3];
			next_bidirDirOut = pwdata[`CGL_BIDIR_DIR_BIT];
			next_bidirPolHigh = pwdata[`CGL_BIDIR_POL_BIT];
			next_outPolHigh = pwdata[`CGL_OUT_POL_BIT];
			next_inPolHigh = pwdata[`CGL_IN_POL_BIT];
			next_softwareOutputLevel = pwdata[`CGL_SW_LEVEL_BIT];
			// unused encoding falls back to the input line
			next_startSel = (pwdata[`CGL_START_SEL_LSB +: 2] == 2'h3) ? 2'h0
				: pwdata[`CGL_START_SEL_LSB +: 2];
			// undefined source codes are stored as off, so they read back as zero and act as off
			if (pwdata[`CGL_BIDIR_SEL_LSB +: 3] == 3'h7) begin
				next_bidirSel = 3'h0;
			end
			if (pwdata[`CGL_OUT_SEL_LSB +: 3] == 3'h7) begin
				next_outSel = 3'h0;
			end
		end
		if (wrAccess && paddr == `CGL_OFS_TMR_DELAY) begin
			next_delayUs = clampUs(pwdata);
		end
		if (wrAccess && paddr == `CGL_OFS_TMR_DUR) begin
			next_durationUs = clampUs(pwdata);
		end
		if (rdAccess) begin
			unique case (paddr)
				`CGL_OFS_LINE_CTRL: next_prdata = ctrlWord;
				`CGL_OFS_TMR_DELAY: next_prdata = {11'h000, delayUs};
				`CGL_OFS_TMR_DUR: next_prdata = {11'h000, durationUs};
				`CGL_OFS_STATUS: next_prdata = {27'h000_0000, pulseTimerActive,
					bidirInputAsserted, inputPinAsserted, bidirLineOut, outputOnlyLine};
				default: next_prdata = 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// line logic
	// ----------------------------------------------------------------
	assign inputPinAsserted = applyPolarity(inputOnlyLine, inPolHigh);
	always_comb begin
		unique case (startSel)
			2'h1: timerStart = exposureBeginEvent;
			2'h2: timerStart = captureRequestEvent;
			default: timerStart = inputPinAsserted & ~inputPrev;
		endcase
	end

	always_comb begin
		next_bidirLineOut = applyPolarity(selectSource(bidirSel, pulseTimerActive,
			softwareOutputLevel, exposureWindowActive, framePeriodActive,
			imageSendingFlag, triggerAcceptReady), bidirPolHigh);
		// off source releases the pad so input stays usable
		next_bidirLineOe = bidirDirOut && (bidirSel != 3'h0);
		next_outputOnlyLine = applyPolarity(selectSource(outSel, pulseTimerActive,
			softwareOutputLevel, exposureWindowActive, framePeriodActive,
			imageSendingFlag, triggerAcceptReady), outPolHigh);
		next_bidirInputAsserted = (~bidirDirOut || bidirSel == 3'h0)
			&& applyPolarity(bidirLineIn, bidirPolHigh);
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			bidirSel <= 3'h0;
			outSel <= 3'h0;
			bidirDirOut <= 1'b1;
			bidirPolHigh <= 1'b0;
			outPolHigh <= 1'b0;
			inPolHigh <= 1'b0;
			softwareOutputLevel <= 1'b0;
			startSel <= 2'h0;
			delayUs <= `CGL_TMR_RST;
			durationUs <= `CGL_TMR_RST;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			bidirLineOut <= 1'b1;
			bidirLineOe <= 1'b0;
			outputOnlyLine <= 1'b1;
			bidirInputAsserted <= 1'b0;
			inputPrev <= 1'b1;
		end else if (clockEnable) begin
			bidirSel <= next_bidirSel;
			outSel <= next_outSel;
			bidirDirOut <= next_bidirDirOut;
			bidirPolHigh <= next_bidirPolHigh;
			outPolHigh <= next_outPolHigh;
			inPolHigh <= next_inPolHigh;
			softwareOutputLevel <= next_softwareOutputLevel;
			startSel <= next_startSel;
			delayUs <= next_delayUs;
			durationUs <= next_durationUs;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			bidirLineOut <= next_bidirLineOut;
			bidirLineOe <= next_bidirLineOe;
			outputOnlyLine <= next_outputOnlyLine;
			bidirInputAsserted <= next_bidirInputAsserted;
			inputPrev <= inputPinAsserted;
		end
	end

	cgl_pulse_timer timerInst (
		.clock(clock),
		.rst(rst),
		.clockEnable(clockEnable),
		.start(timerStart),
		.delayUs(delayUs),
		.durationUs(durationUs),
		.active(pulseTimerActive)
	);
endmodule

// ---- rtl/cgl_map.svh ----
// register offsets, field positions, reset values and timing counts for the camera line block
// assumes a 200 MHz clock and an APB slave with 32-bit data
// Operation
// - software sets bidirectional line direction; output after reset
// - bidirectional output driven from seven-way source select; off after reset
// - output-only line uses the same seven-way select; off after reset
// - per-line polarity for output and input; low active after reset
// - bidirectional input valid whenever its source is off, any direction
// - pulse timer delay and duration, 0 to 2000000 us, zero after reset
// - timer starts on input line, exposure begin or capture request
`ifndef CGL_MAP_SVH
`define CGL_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CGL_OFS_LINE_CTRL 12'h000
`define CGL_OFS_TMR_DELAY 12'h004
`define CGL_OFS_TMR_DUR 12'h008
`define CGL_OFS_STATUS 12'h00C

// ----------------------------------------------------------------
// line control fields
// ----------------------------------------------------------------
`define CGL_BIDIR_SEL_LSB 0
`define CGL_OUT_SEL_LSB 4
`define CGL_BIDIR_DIR_BIT 8
`define CGL_BIDIR_POL_BIT 9
`define CGL_OUT_POL_BIT 10
`define CGL_IN_POL_BIT 11
`define CGL_SW_LEVEL_BIT 12
`define CGL_START_SEL_LSB 16
`define CGL_LINE_CTRL_RST 32'h0000_0100

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CGL_TMR_MAX_US 2000000
`define CGL_CLK_MHZ 200
`define CGL_CYC_PER_US 8'hC8
`define CGL_TMR_RST 21'h00_0000

`endif

// ---- rtl/cgl_pkg.sv ----
// types shared by the camera line block
// assumes the map header supplies all numbers
package cgl_pkg;
	typedef enum logic [2:0] {
		CGL_SRC_OFF = 3'h0,
		CGL_SRC_TIMER = 3'h1,
		CGL_SRC_SOFT = 3'h2,
		CGL_SRC_EXPO = 3'h3,
		CGL_SRC_FRAME = 3'h4,
		CGL_SRC_SEND = 3'h5,
		CGL_SRC_TRIG_RDY = 3'h6
	} cgl_src_t;

	typedef enum logic [1:0] {
		CGL_START_INPUT = 2'h0,
		CGL_START_EXPO = 2'h1,
		CGL_START_CAPTURE = 2'h2
	} cgl_start_t;

	typedef enum logic [1:0] {
		CGL_TS_IDLE = 2'b00,
		CGL_TS_DELAY = 2'b01,
		CGL_TS_ACTIVE = 2'b10
	} cgl_tstate_t;
endpackage

// ---- rtl/cgl_pulse_timer.sv ----
// delay then duration pulse timer counted in microseconds
// assumes start is a one-cycle pulse in the clock domain
`timescale 1ns/1ps
`include "cgl_map.svh"
module cgl_pulse_timer (
	input wire logic clock,
	input wire logic rst,
	input wire logic clockEnable,
	input wire logic start,
	input wire logic [20:0] delayUs,
	input wire logic [20:0] durationUs,
	output logic active
);
	cgl_pkg::cgl_tstate_t state, next_state;
	logic [7:0] preScale, next_preScale;
	logic [20:0] usCount, next_usCount;
	logic next_active;
	logic usTick;

	assign usTick = (preScale == `CGL_CYC_PER_US - 8'h01);

	// ----------------------------------------------------------------
	// sequencing
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_preScale = usTick ? 8'h00 : preScale + 8'h01;
		next_usCount = usCount;
		unique case (state)
			cgl_pkg::CGL_TS_IDLE: begin
				next_preScale = 8'h00;
				next_usCount = 21'h00_0000;
				if (start) begin
					// zero delay goes straight to active, zero duration gives no pulse
					if (delayUs != 21'h00_0000) begin
						next_state = cgl_pkg::CGL_TS_DELAY;
					end else if (durationUs != 21'h00_0000) begin
						next_state = cgl_pkg::CGL_TS_ACTIVE;
					end
				end
			end
			cgl_pkg::CGL_TS_DELAY: begin
				if (usTick) begin
					next_usCount = usCount + 21'h00_0001;
					if (usCount + 21'h00_0001 >= delayUs) begin
						next_usCount = 21'h00_0000;
						next_state = (durationUs != 21'h00_0000) ? cgl_pkg::CGL_TS_ACTIVE
							: cgl_pkg::CGL_TS_IDLE;
					end
				end
			end
			cgl_pkg::CGL_TS_ACTIVE: begin
				if (usTick) begin
					next_usCount = usCount + 21'h00_0001;
					if (usCount + 21'h00_0001 >= durationUs) begin
						next_state = cgl_pkg::CGL_TS_IDLE;
					end
				end
			end
			default: next_state = cgl_pkg::CGL_TS_IDLE;
		endcase
		next_active = (next_state == cgl_pkg::CGL_TS_ACTIVE);
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state <= cgl_pkg::CGL_TS_IDLE;
			preScale <= 8'h00;
			usCount <= 21'h00_0000;
			active <= 1'b0;
		end else if (clockEnable) begin
			state <= next_state;
			preScale <= next_preScale;
			usCount <= next_usCount;
			active <= next_active;
		end
	end
endmodule
